// [design/qgp_phy_mgmt.sv]
// one phy of the quad: strap capture, management registers, interrupt
// assumes strap pins and mdc/mdio are asynchronous to core_clk_i
// Overview of operation
// - fixed addresses zero to three per port
// - pause strap off clears advert pause bits
// - strap 1110: autoneg, advertise all, master
// - crossover strap zero keeps pairs unswapped
// - clock disable strap stops 125 output
// - config 0100 selects sgmii without clock
// - media disable strap keeps interface off
// - sleep disable strap keeps energy detect off
// - select strap zero means mdio access
// - polarity strap one makes interrupt low
// - one shared active low reset line
// - serial pair per direction to mac
`timescale 1ns/1ps
`default_nettype none
`include "qgp_consts.svh"
module qgp_phy_mgmt
    import qgp_pkg::*;
#(
    parameter logic [1:0] PORT_INDEX = 2'd0
)(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic phy_shared_reset_n_i,
    input wire logic pause_enable_strap_i,
    input wire logic [3:0] copper_autoneg_config_i,
    input wire logic crossover_enable_strap_i,
    input wire logic clk125_output_disable_i,
    input wire logic [3:0] hw_config_mode_i,
    input wire logic media_interface_disable_i,
    input wire logic energy_detect_disable_i,
    input wire logic mgmt_interface_select_i,
    input wire logic irq_polarity_strap_i,
    input wire logic phy_mgmt_clock_i,
    input wire logic phy_mgmt_data_i,
    output logic phy_mgmt_data_o,
    output logic phy_mgmt_data_oe_n_o,
    input wire logic link_up_i,
    input wire logic link_event_i,
    output logic phy_irq_n_o,
    output logic clk125_oe_n_o,
    output logic autoneg_enable_o,
    output logic mdix_auto_en_o,
    output logic energy_detect_en_o,
    output logic media_if_en_o,
    output logic sgmii_mode_o,
    output logic sgmii_an_en_o,
    output logic serial_link_en_o
);
    logic rst_n, rst_in_n;
    logic [1:0] rst_sync_ff;
    logic [15:0] strap_in, sync1_ff, sync2_ff, strap_ff, nxt_strap;
    logic [1:0] cap_ff, nxt_cap;
    logic cap;
    logic [2:0] mdc_s_ff;
    logic [1:0] mdio_s_ff;
    logic [15:0] ctrl_ff, nxt_ctrl, adv_ff, nxt_adv, gctl_ff, nxt_gctl;
    logic [15:0] sctl_ff, nxt_sctl, ien_ff, nxt_ien, ist_ff, nxt_ist;
    logic [15:0] rd_ff, nxt_rd;
    logic irq_n_ff, nxt_irq_n;
    logic [6:0] out_ff, nxt_out;
    logic pend;
    qgp_mdio_if bus ();

    // one line resets every port of the quad together
    assign rst_in_n = nrst_i & phy_shared_reset_n_i;

    // reset release passes two flops, assertion stays immediate
    always_ff @(posedge core_clk_i or negedge rst_in_n) begin
        if (!rst_in_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ========================================
    // strap and pin synchronisers
    assign strap_in = {1'b0, irq_polarity_strap_i, mgmt_interface_select_i,
                       energy_detect_disable_i, media_interface_disable_i,
                       hw_config_mode_i, clk125_output_disable_i,
                       crossover_enable_strap_i, copper_autoneg_config_i,
                       pause_enable_strap_i};
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 16'h0000;
            sync2_ff <= 16'h0000;
            mdc_s_ff <= 3'h0;
            mdio_s_ff <= 2'h0;
        end else begin
            sync1_ff <= strap_in;
            sync2_ff <= sync1_ff;
            mdc_s_ff <= {mdc_s_ff[1:0], phy_mgmt_clock_i};
            mdio_s_ff <= {mdio_s_ff[0], phy_mgmt_data_i};
        end
    end

    // ========================================
    // strap capture on the third edge after reset release
    assign cap = (cap_ff == 2'd2);
    always_comb begin
        nxt_cap = (cap_ff == 2'd3) ? cap_ff : cap_ff + 2'd1;
        nxt_strap = cap ? sync2_ff : strap_ff;
    end

    // ========================================
    // management register file
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_adv = adv_ff;
        nxt_gctl = gctl_ff;
        nxt_sctl = sctl_ff;
        nxt_ien = ien_ff;
        nxt_ist = ist_ff;
        nxt_rd = rd_ff;
        if (cap) begin
            // strap-derived power-up values
            nxt_adv = sync2_ff[0] ? (`QGP_ADV_RST | `QGP_ADV_PAUSE)
                                  : `QGP_ADV_RST;
            if (sync2_ff[4:1] == `QGP_ANEG_ALL_MASTER) begin
                nxt_ctrl = `QGP_CTRL_RST;
                nxt_gctl = `QGP_GCTL_MASTER;
            end else begin
                nxt_ctrl = `QGP_CTRL_NOAN;
                nxt_gctl = `QGP_GCTL_RST;
            end
            nxt_sctl = (sync2_ff[5] ? `QGP_SCTL_XOVER : `QGP_SCTL_RST)
                | (sync2_ff[12] ? `QGP_SCTL_RST : `QGP_SCTL_EDET);
        end else if (bus.wr_stb) begin
            case (bus.reg_addr)
                `QGP_REG_CTRL: nxt_ctrl = bus.wr_data;
                `QGP_REG_ADV: nxt_adv = bus.wr_data;
                `QGP_REG_GCTL: nxt_gctl = bus.wr_data;
                `QGP_REG_SCTL: nxt_sctl = bus.wr_data;
                `QGP_REG_IEN: nxt_ien = bus.wr_data;
                default: nxt_ien = ien_ff;
            endcase
        end
        if (bus.rd_stb) begin
            case (bus.reg_addr)
                `QGP_REG_CTRL: nxt_rd = ctrl_ff;
                `QGP_REG_STAT: nxt_rd = `QGP_STAT_RST
                    | {13'h0000, link_up_i, 2'b00};
                `QGP_REG_ADV: nxt_rd = adv_ff;
                `QGP_REG_GCTL: nxt_rd = gctl_ff;
                `QGP_REG_SCTL: nxt_rd = sctl_ff;
                `QGP_REG_IEN: nxt_rd = ien_ff;
                `QGP_REG_IST: nxt_rd = ist_ff;
                `QGP_REG_XST: nxt_rd = {strap_ff[11], 11'h000, strap_ff[10:7]};
                default: nxt_rd = 16'h0000;
            endcase
            if (bus.reg_addr == `QGP_REG_IST) begin
                nxt_ist = 16'h0000; // cleared by reading
            end
        end
        if (link_event_i) begin
            nxt_ist[`QGP_IST_LINK_BIT] = 1'b1; // set wins over the clear
        end
    end
    assign bus.rd_data = rd_ff;

    // ========================================
    // interrupt and strap-steered outputs
    always_comb begin
        pend = |(ist_ff & ien_ff);
        // polarity strap one: pending shows as a low level
        nxt_irq_n = strap_ff[14] ? ~pend : pend;
        nxt_out[0] = strap_ff[6]; // 125 clock not driven when set
        nxt_out[1] = ctrl_ff[`QGP_CTRL_AN_BIT];
        nxt_out[2] = |sctl_ff[`QGP_SCTL_XOVER_HI:`QGP_SCTL_XOVER_LO];
        nxt_out[3] = |sctl_ff[`QGP_SCTL_EDET_HI:`QGP_SCTL_EDET_LO];
        nxt_out[4] = ~strap_ff[11];
        // sgmii toward the mac, no forwarded clock
        nxt_out[5] = (strap_ff[10:7] == `QGP_HWCFG_SGMII_NOCLK);
        // one serial pair each way runs only in sgmii mode
        nxt_out[6] = (strap_ff[10:7] == `QGP_HWCFG_SGMII_NOCLK);
        // hold reset levels until straps are captured
        if (cap_ff != 2'd3) begin
            nxt_irq_n = irq_n_ff;
            nxt_out = out_ff;
        end
    end

    // state registers of strap, register and output groups
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cap_ff <= 2'd0;
            strap_ff <= 16'h0000;
            ctrl_ff <= `QGP_CTRL_RST;
            adv_ff <= `QGP_ADV_RST;
            gctl_ff <= `QGP_GCTL_RST;
            sctl_ff <= `QGP_SCTL_RST;
            ien_ff <= 16'h0000;
            ist_ff <= 16'h0000;
            rd_ff <= 16'h0000;
            irq_n_ff <= 1'b1;
            out_ff <= 7'h01;
        end else begin
            cap_ff <= nxt_cap;
            strap_ff <= nxt_strap;
            ctrl_ff <= nxt_ctrl;
            adv_ff <= nxt_adv;
            gctl_ff <= nxt_gctl;
            sctl_ff <= nxt_sctl;
            ien_ff <= nxt_ien;
            ist_ff <= nxt_ist;
            rd_ff <= nxt_rd;
            irq_n_ff <= nxt_irq_n;
            out_ff <= nxt_out;
        end
    end

    assign phy_irq_n_o = irq_n_ff;
    assign clk125_oe_n_o = out_ff[0];
    assign autoneg_enable_o = out_ff[1];
    assign mdix_auto_en_o = out_ff[2];
    assign energy_detect_en_o = out_ff[3];
    assign media_if_en_o = out_ff[4];
    assign sgmii_mode_o = out_ff[5];
    assign sgmii_an_en_o = out_ff[5] & out_ff[1];
    assign serial_link_en_o = out_ff[6];

    // ========================================
    // frame decoder on the management pins
    qgp_mdio_frame qgp_mdio_frame_inst (
        .core_clk_i (core_clk_i),
        .rst_n_i (rst_n),
        .mdc_rise_i (mdc_s_ff[1] & ~mdc_s_ff[2]),
        .mdc_fall_i (~mdc_s_ff[1] & mdc_s_ff[2]),
        .mdio_bit_i (mdio_s_ff[1]),
        .enable_i (~strap_ff[13]),
        .phy_addr_i (`QGP_PHY_ADDR_BASE + {3'b000, PORT_INDEX}),
        .mdio_o (phy_mgmt_data_o),
        .mdio_oe_n_o (phy_mgmt_data_oe_n_o),
        .bus (bus)
    );

    // ========================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_cap;
        cap_ff == 2'd1 ##1 cap_ff == 2'd2;
    endsequence
    property p_pause_off;
        (s_cap ##0 !sync2_ff[0]) |=> adv_ff[11:10] == 2'b00;
    endproperty
    a_pause_off: assert property (p_pause_off)
        else $error("pause advert not cleared by strap");
    property p_aneg;
        (cap && sync2_ff[4:1] == `QGP_ANEG_ALL_MASTER) |=>
            ctrl_ff[`QGP_CTRL_AN_BIT] && gctl_ff[`QGP_GCTL_MASTER_BIT]
            && gctl_ff[9:8] == 2'b11 ##1 autoneg_enable_o;
    endproperty
    a_aneg: assert property (p_aneg)
        else $error("autoneg strap not applied");
    property p_xover;
        (cap && !sync2_ff[5] && !bus.wr_stb) |=> ##1 !mdix_auto_en_o;
    endproperty
    a_xover: assert property (p_xover)
        else $error("crossover enabled with strap low");
    property p_clk125;
        strap_ff[6] |=> clk125_oe_n_o;
    endproperty
    a_clk125: assert property (p_clk125)
        else $error("125 clock driven while disabled");
    property p_sgmii;
        (cap && sync2_ff[10:7] == `QGP_HWCFG_SGMII_NOCLK) |=> ##1
            sgmii_mode_o && serial_link_en_o;
    endproperty
    a_sgmii: assert property (p_sgmii)
        else $error("sgmii mode not selected");
    property p_media;
        strap_ff[11] |=> !media_if_en_o;
    endproperty
    a_media: assert property (p_media)
        else $error("media interface on while disabled");
    property p_edet;
        (cap && sync2_ff[12] && !bus.wr_stb) |=> ##1 !energy_detect_en_o;
    endproperty
    a_edet: assert property (p_edet)
        else $error("energy detect on while disabled");
    property p_irq_low;
        (pend && strap_ff[14]) |=> !phy_irq_n_o;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("pending interrupt not shown low");
endmodule // qgp_phy_mgmt
`default_nettype wire

// [design/qgp_consts.svh]
// constants for the quad phy strap and management block
// assumes inclusion by every design file that needs offsets or values
`ifndef QGP_CONSTS_SVH
`define QGP_CONSTS_SVH
// management frame
`define QGP_PRE_LEN 6'd32
`define QGP_HDR_LAST 5'd12
`define QGP_WDAT_LAST 5'd15
`define QGP_RD_TA_LO 5'd1
`define QGP_RD_END 5'd18
`define QGP_OP_RD 2'b10
`define QGP_OP_WR 2'b01
`define QGP_PHY_ADDR_BASE 5'h00
// management register addresses
`define QGP_REG_CTRL 5'h00
`define QGP_REG_STAT 5'h01
`define QGP_REG_ADV 5'h04
`define QGP_REG_GCTL 5'h09
`define QGP_REG_SCTL 5'h10
`define QGP_REG_IEN 5'h12
`define QGP_REG_IST 5'h13
`define QGP_REG_XST 5'h1b
// reset values
`define QGP_CTRL_RST 16'h1140
`define QGP_CTRL_NOAN 16'h0140
`define QGP_STAT_RST 16'h7949
`define QGP_ADV_RST 16'h01e1
`define QGP_ADV_PAUSE 16'h0c00
`define QGP_GCTL_RST 16'h0300
`define QGP_GCTL_MASTER 16'h0700
`define QGP_SCTL_RST 16'h0000
`define QGP_SCTL_XOVER 16'h0060
`define QGP_SCTL_EDET 16'h0300
// field positions
`define QGP_CTRL_AN_BIT 12
`define QGP_STAT_LINK_BIT 2
`define QGP_GCTL_MASTER_BIT 10
`define QGP_SCTL_XOVER_HI 6
`define QGP_SCTL_XOVER_LO 5
`define QGP_SCTL_EDET_HI 9
`define QGP_SCTL_EDET_LO 8
`define QGP_IST_LINK_BIT 0
// strap values
`define QGP_ANEG_ALL_MASTER 4'he
`define QGP_HWCFG_SGMII_NOCLK 4'h4
`endif

// [design/qgp_pkg.sv]
// types for the quad phy strap and management block
// assumes nothing beyond the consts header
package qgp_pkg;
    // management frame states, one-hot
    typedef enum logic [4:0] {
        QGP_PRE = 5'h01,
        QGP_HDR = 5'h02,
        QGP_TA = 5'h04,
        QGP_WDAT = 5'h08,
        QGP_RDAT = 5'h10
    } qgp_frm_state_t;
endpackage

// [design/qgp_mdio_if.sv]
// interface between frame decoder and register file
// assumes one clock domain for both ends
`timescale 1ns/1ps
`default_nettype none
interface qgp_mdio_if;
    logic wr_stb;
    logic rd_stb;
    logic [4:0] reg_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    modport frame (output wr_stb, output rd_stb, output reg_addr,
                   output wr_data, input rd_data);
    modport regs (input wr_stb, input rd_stb, input reg_addr,
                  input wr_data, output rd_data);
endinterface
`default_nettype wire

// [design/qgp_mdio_frame.sv]
// management frame decoder: preamble, header, turnaround, data
// assumes mdc edges and mdio already synchronised to core_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "qgp_consts.svh"
module qgp_mdio_frame
    import qgp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic mdc_rise_i,
    input wire logic mdc_fall_i,
    input wire logic mdio_bit_i,
    input wire logic enable_i,
    input wire logic [4:0] phy_addr_i,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    qgp_mdio_if.frame bus
);
    qgp_frm_state_t state_ff, nxt_state;
    logic [5:0] ones_ff, nxt_ones;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [15:0] sh_ff, nxt_sh;
    logic [15:0] out_ff, nxt_out;
    logic [4:0] addr_ff, nxt_addr;
    logic mdo_ff, nxt_mdo;
    logic oe_n_ff, nxt_oe_n;
    logic wr_ff, nxt_wr;
    logic rd_ff, nxt_rd;
    logic [12:0] hdr;
    logic hit;

    // ========================================
    // frame sequencing
    always_comb begin
        nxt_state = state_ff;
        nxt_ones = ones_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_out = out_ff;
        nxt_addr = addr_ff;
        nxt_mdo = mdo_ff;
        nxt_oe_n = oe_n_ff;
        nxt_wr = 1'b0;
        nxt_rd = 1'b0;
        hdr = {sh_ff[11:0], mdio_bit_i};
        // start bit, own address, and the serial side selected
        hit = hdr[12] && enable_i && (hdr[9:5] == phy_addr_i);
        case (state_ff)
            QGP_PRE: begin
                if (mdc_rise_i) begin
                    if (mdio_bit_i) begin
                        if (ones_ff != `QGP_PRE_LEN) begin
                            nxt_ones = ones_ff + 6'd1;
                        end
                    end else if (ones_ff == `QGP_PRE_LEN) begin
                        nxt_state = QGP_HDR; // first start bit seen
                        nxt_cnt = 5'd0;
                    end else begin
                        nxt_ones = 6'd0;
                    end
                end
            end
            QGP_HDR: begin
                if (mdc_rise_i) begin
                    nxt_sh = {sh_ff[14:0], mdio_bit_i};
                    nxt_cnt = cnt_ff + 5'd1;
                    if (cnt_ff == `QGP_HDR_LAST) begin
                        nxt_ones = 6'd0;
                        nxt_cnt = 5'd0;
                        nxt_addr = hdr[4:0];
                        if (hit && hdr[11:10] == `QGP_OP_RD) begin
                            nxt_state = QGP_RDAT;
                            nxt_rd = 1'b1;
                        end else if (hit && hdr[11:10] == `QGP_OP_WR) begin
                            nxt_state = QGP_TA;
                        end else begin
                            nxt_state = QGP_PRE; // not ours: stay off the wire
                        end
                    end
                end
            end
            QGP_TA: begin
                if (mdc_rise_i) begin
                    nxt_cnt = cnt_ff + 5'd1;
                    if (cnt_ff == 5'd1) begin
                        nxt_state = QGP_WDAT;
                        nxt_cnt = 5'd0;
                    end
                end
            end
            QGP_WDAT: begin
                if (mdc_rise_i) begin
                    nxt_sh = {sh_ff[14:0], mdio_bit_i};
                    nxt_cnt = cnt_ff + 5'd1;
                    if (cnt_ff == `QGP_WDAT_LAST) begin
                        nxt_wr = 1'b1;
                        nxt_state = QGP_PRE;
                    end
                end
            end
            QGP_RDAT: begin
                if (mdc_fall_i) begin
                    nxt_cnt = cnt_ff + 5'd1;
                    if (cnt_ff == `QGP_RD_TA_LO) begin
                        nxt_oe_n = 1'b0; // second turnaround bit low
                        nxt_mdo = 1'b0;
                        nxt_out = bus.rd_data;
                    end else if (cnt_ff == `QGP_RD_END) begin
                        nxt_oe_n = 1'b1;
                        nxt_state = QGP_PRE;
                    end else if (cnt_ff > `QGP_RD_TA_LO) begin
                        nxt_mdo = out_ff[15];
                        nxt_out = {out_ff[14:0], 1'b0};
                    end
                end
            end
            default: begin
                nxt_state = QGP_PRE;
                nxt_oe_n = 1'b1;
            end
        endcase
    end

    // registers of the frame sequencer
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= QGP_PRE;
            ones_ff <= 6'd0;
            cnt_ff <= 5'd0;
            sh_ff <= 16'h0000;
            out_ff <= 16'h0000;
            addr_ff <= 5'h00;
            mdo_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ones_ff <= nxt_ones;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            out_ff <= nxt_out;
            addr_ff <= nxt_addr;
            mdo_ff <= nxt_mdo;
            oe_n_ff <= nxt_oe_n;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    assign mdio_o = mdo_ff;
    assign mdio_oe_n_o = oe_n_ff;
    assign bus.wr_stb = wr_ff;
    assign bus.rd_stb = rd_ff;
    assign bus.reg_addr = addr_ff;
    assign bus.wr_data = sh_ff;

    // ========================================
    // checks
    property p_mgmt_interface_select;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !enable_i |=> !rd_ff && !wr_ff;
    endproperty
    a_mgmt_interface_select: assert property (p_mgmt_interface_select)
        else $error("management access taken while serial side off");

    sequence s_rd_hit;
        state_ff == QGP_HDR && mdc_rise_i && cnt_ff == `QGP_HDR_LAST
            && hit && hdr[11:10] == `QGP_OP_RD;
    endsequence
    property p_addr_match;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_rd_hit |=> rd_ff && state_ff == QGP_RDAT && oe_n_ff;
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("read frame to own address not answered");

    property p_foreign;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == QGP_HDR && mdc_rise_i && cnt_ff == `QGP_HDR_LAST
            && hdr[9:5] != phy_addr_i) |=> state_ff == QGP_PRE && !rd_ff;
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("frame for another address was taken");
endmodule // qgp_mdio_frame
`default_nettype wire

// [design/qgp_phy_mgmt_fix.sv]
// spare design unit: holds no logic of its own
// assumes nothing of its surroundings
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [sim/qgp_mgr_model.sv]
// management manager model: drives mdc and frames on the mdio wire
// assumes a 40 MHz core clock and a pulled-up mdio line
`timescale 1ns/1ps
`default_nettype none
module qgp_mgr_model (
    input wire logic core_clk_i,
    input wire logic phy_data_i,
    input wire logic phy_oe_n_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic done_o,
    output logic [15:0] rdat_o
);
    logic drv_en = 1'b0;
    logic drv_bit = 1'b0;
    logic smp;
    // ========================================
    // wire level: manager, phy, else pull-up
    assign mdio_o = drv_en ? drv_bit : (phy_oe_n_i ? 1'b1 : phy_data_i);
    initial begin
        mdc_o = 1'b0;
        done_o = 1'b0;
        rdat_o = 16'h0000;
    end
    // one mdc period, five core cycles per half, sample late in high
    task automatic tick(input logic en, input logic b);
        @(posedge core_clk_i);
        mdc_o <= 1'b0;
        drv_en <= en;
        drv_bit <= b;
        repeat (5) @(posedge core_clk_i);
        mdc_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        @(negedge core_clk_i);
        smp = mdio_o;
    endtask
    // whole frame: preamble, start, op, addresses, turnaround, data
    task automatic xfer(input logic rd, input logic [4:0] pa,
            input logic [4:0] ra, input logic [15:0] wd);
        logic [31:0] hdr;
        hdr = {2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
        for (int i = 0; i < 32; i++) tick(1'b1, 1'b1);
        for (int i = 31; i >= 18; i--) tick(1'b1, hdr[i]);
        for (int i = 17; i >= 0; i--) begin
            tick(!rd, hdr[i]);
            if (i < 16) rdat_o[i] = smp;
        end
        tick(1'b0, 1'b1);
        @(posedge core_clk_i);
        done_o <= rd;
        mdc_o <= 1'b0; // idle low, as the decoder's edge detector resets
        @(posedge core_clk_i);
        done_o <= 1'b0;
    endtask
endmodule // qgp_mgr_model
`default_nettype wire

// [sim/quad_gige_phy_strap_mgmt_bench.sv]
// bench for one phy port: strap results, register reads, irq, reset
// assumes the manager model and the design files compiled before
`timescale 1ns/1ps
`default_nettype none
module quad_gige_phy_strap_mgmt_bench;
    logic clk = 1'b0, nrst = 1'b0, shr_n = 1'b1, pause = 1'b0;
    logic [3:0] aneg = 4'he, hwcfg = 4'h4;
    logic xover = 1'b0, dis125 = 1'b1, dis_m = 1'b1, no_sleep = 1'b1;
    logic sel = 1'b0, pol = 1'b1, link_up = 1'b1, link_ev = 1'b0;
    logic mdc, mdio, pdo, poe_n, irq_n, c125, an_en, mdix, edet;
    logic media, sgmii, sg_an, ser, done;
    logic [15:0] rdat;
    logic [15:0] exp_q[$];
    logic [4:0] pa;
    int fails = 0, check_count = 0, seed = 28696;
    always #12.5 clk = ~clk;
    qgp_phy_mgmt #(.PORT_INDEX(2'd2)) qgp_phy_mgmt_inst (
        .core_clk_i(clk), .nrst_i(nrst), .phy_shared_reset_n_i(shr_n),
        .pause_enable_strap_i(pause), .copper_autoneg_config_i(aneg),
        .crossover_enable_strap_i(xover), .clk125_output_disable_i(dis125),
        .hw_config_mode_i(hwcfg), .media_interface_disable_i(dis_m),
        .energy_detect_disable_i(no_sleep), .mgmt_interface_select_i(sel),
        .irq_polarity_strap_i(pol), .phy_mgmt_clock_i(mdc),
        .phy_mgmt_data_i(mdio), .phy_mgmt_data_o(pdo),
        .phy_mgmt_data_oe_n_o(poe_n), .link_up_i(link_up),
        .link_event_i(link_ev), .phy_irq_n_o(irq_n), .clk125_oe_n_o(c125),
        .autoneg_enable_o(an_en), .mdix_auto_en_o(mdix),
        .energy_detect_en_o(edet), .media_if_en_o(media),
        .sgmii_mode_o(sgmii), .sgmii_an_en_o(sg_an),
        .serial_link_en_o(ser));
    qgp_mgr_model qgp_mgr_model_inst (.core_clk_i(clk), .phy_data_i(pdo),
        .phy_oe_n_i(poe_n), .mdc_o(mdc), .mdio_o(mdio), .done_o(done),
        .rdat_o(rdat));
    // ========================================
    // compare tasks and verdict
    task automatic check_word(input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("FAIL %0t read %h expected %h", $time, g, e);
        end
    endtask
    task automatic check_bit(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("FAIL %0t level %b expected %b", $time, g, e);
        end
    endtask
    task automatic conclude;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // read with expected value noted for the watcher
    task automatic rd(input logic [4:0] a, input logic [4:0] r,
            input logic [15:0] e);
        exp_q.push_back(e);
        qgp_mgr_model_inst.xfer(1'b1, a, r, 16'h0000);
    endtask
    task automatic pulse_shared;
        @(posedge clk);
        shr_n <= 1'b0;
        repeat (2) @(posedge clk);
        shr_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // watcher: each finished read takes the oldest note
    always @(posedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("FAIL %0t unexpected read", $time);
            end else begin
                check_word(exp_q.pop_front(), rdat);
            end
        end
    end
    // watchdog on the whole run
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
    // ========================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        check_bit(c125, 1'b1);
        check_bit(an_en, 1'b1);
        check_bit(mdix, 1'b0);
        check_bit(edet, 1'b0);
        check_bit(media, 1'b0);
        check_bit(sgmii, 1'b1);
        check_bit(sg_an, 1'b1);
        check_bit(ser, 1'b1);
        check_bit(irq_n, 1'b1);
        rd(5'd2, 5'h04, 16'h01e1);
        rd(5'd2, 5'h09, 16'h0700);
        rd(5'd2, 5'h00, 16'h1140);
        rd(5'd2, 5'h10, 16'h0000);
        rd(5'd2, 5'h01, 16'h794d);
        rd(5'd2, 5'h1b, 16'h8004);
        for (int k = 0; k < 3; k++) begin
            pa = 5'($random(seed));
            if (pa == 5'd2) pa = 5'd3;
            rd(pa, 5'h04, 16'hffff);
        end
        qgp_mgr_model_inst.xfer(1'b0, 5'd2, 5'h12, 16'h0001);
        @(posedge clk);
        link_ev <= 1'b1;
        @(posedge clk);
        link_ev <= 1'b0;
        repeat (4) @(posedge clk);
        check_bit(irq_n, 1'b0);
        rd(5'd2, 5'h13, 16'h0001);
        repeat (3) @(posedge clk);
        check_bit(irq_n, 1'b1);
        qgp_mgr_model_inst.xfer(1'b0, 5'd2, 5'h04, 16'h0000);
        rd(5'd2, 5'h04, 16'h0000);
        pulse_shared();
        rd(5'd2, 5'h04, 16'h01e1);
        sel <= 1'b1;
        pulse_shared();
        rd(5'd2, 5'h04, 16'hffff);
        repeat (2) @(posedge clk);
        if (exp_q.size() != 0) fails++;
        conclude();
    end
endmodule // quad_gige_phy_strap_mgmt_bench
`default_nettype wire
